// ---- serial_readout.sv ----
`timescale 1ns/1ps
module serial_readout #(
  parameter int WORD_W = 32
) (
  input  wire logic              core_clk,
  input  wire logic              rst_n,
  input  wire logic              cs_n_pin,
  input  wire logic              sclk_pin,
  input  wire logic              sdi_pin,
  output logic                   serial_out_line_a,
  output logic                   shared_flag_output_pin,
  output logic                   ready_strobe_pin,
  input  wire logic              flag_level,
  input  wire logic              sample_valid,
  output logic                   sample_ready,
  input  wire logic [WORD_W-1:0] sample_word,
  output logic [3:0]             device_address
);

  // ****************************************************************
  // Pin synchronisers.
  // ****************************************************************
  logic [1:0] cs_sync_q;
  logic [1:0] sclk_sync_q;
  logic [1:0] sdi_sync_q;
  logic       cs_n_s;
  logic       sclk_s;
  logic       sdi_s;
  logic       sclk_prev_q;

  // Two stages on every pin; only stage two is read.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cs_sync_q   <= 2'b11;
      sclk_sync_q <= 2'b00;
      sdi_sync_q  <= 2'b00;
      sclk_prev_q <= 1'b0;
    end else begin
      cs_sync_q   <= {cs_sync_q[0], cs_n_pin};
      sclk_sync_q <= {sclk_sync_q[0], sclk_pin};
      sdi_sync_q  <= {sdi_sync_q[0], sdi_pin};
      sclk_prev_q <= sclk_sync_q[1];
    end
  end
  assign cs_n_s = cs_sync_q[1];
  assign sclk_s = sclk_sync_q[1];
  assign sdi_s  = sdi_sync_q[1];

  // ****************************************************************
  // Configuration registers.
  // ****************************************************************
  logic [31:0] regs_q [readout_pkg::NUM_REGS];
  logic [1:0]  wr_mode;
  logic [1:0]  out_mode;
  logic        sync_clk_sel;
  logic        dual_out;

  // Map a byte address to a register slot; gaps return no hit.
  function automatic logic [4:0] reg_slot(input logic [7:0] addr);
    logic [7:0] base;
    base = {addr[7:2], 2'b00};
    unique case (base)
      readout_pkg::ADDR_IDENTITY:    reg_slot = 5'h10;
      readout_pkg::ADDR_RESET_PWR:   reg_slot = 5'h11;
      readout_pkg::ADDR_WRITE_PROT:  reg_slot = 5'h12;
      readout_pkg::ADDR_READ_OUT:    reg_slot = 5'h13;
      readout_pkg::ADDR_WORD_CTL:    reg_slot = 5'h14;
      readout_pkg::ADDR_SPAN_SEL:    reg_slot = 5'h15;
      readout_pkg::ADDR_THRESH_FLAG: reg_slot = 5'h16;
      readout_pkg::ADDR_UPPER_LIM:   reg_slot = 5'h17;
      readout_pkg::ADDR_LOWER_LIM:   reg_slot = 5'h18;
      default:                       reg_slot = 5'h00;
    endcase
  endfunction

  // Writable mask per slot; reserved identity bits never store.
  function automatic logic [31:0] wmask(input logic [3:0] idx);
    unique case (idx)
      4'd0:    wmask = readout_pkg::WMASK_IDENTITY;
      4'd2:    wmask = readout_pkg::WMASK_WRITE_PROT;
      4'd3:    wmask = readout_pkg::WMASK_READ_OUT;
      default: wmask = readout_pkg::WMASK_OTHER;
    endcase
  endfunction

  assign wr_mode  = regs_q[2][readout_pkg::WR_PROT_LSB +: 2];
  assign out_mode = regs_q[3][readout_pkg::OUT_PROT_LSB +: 2];
  assign sync_clk_sel = regs_q[3][readout_pkg::SYNC_CLK_SEL_BIT];
  // Dual output only on the exact pattern; 01 and 10 stay single.
  assign dual_out = (regs_q[3][readout_pkg::SECOND_CFG_LSB +: 2]
                     == readout_pkg::SECOND_CFG_DUAL);
  assign device_address =
    regs_q[0][readout_pkg::DEV_ADDR_LSB +: 4];

  // ****************************************************************
  // Frame engine: host-clocked command shift-in and data shift-out.
  // ****************************************************************
  typedef enum {ST_IDLE, ST_FRAME, ST_DONE} frame_state_t;
  frame_state_t st_q;
  logic        cpol;
  logic        cpha;
  logic        lead_edge;
  logic        trail_edge;
  logic        cap_edge;
  logic        launch_edge;
  logic [5:0]  bit_cnt_q;
  logic [31:0] cmd_q;
  logic [WORD_W-1:0] out_shift_q;
  logic        line_a_q;
  logic        line_b_q;
  logic        src_mode;
  logic        buf_valid;
  logic        buf_ready;
  logic [WORD_W-1:0] buf_word;
  logic        load;

  // Read and write follow the written protocol field.
  // Mode bit 1 is the idle clock level and bit 0 the phase: modes 00
  // and 10 launch the first bit at chip select, 01 and 11 on an edge.
  assign cpol = wr_mode[1];
  assign cpha = wr_mode[0];
  assign lead_edge  = (sclk_s != sclk_prev_q) && (sclk_s != cpol);
  assign trail_edge = (sclk_s != sclk_prev_q) && (sclk_s == cpol);
  assign cap_edge    = cpha ? trail_edge : lead_edge;
  assign launch_edge = cpha ? lead_edge : trail_edge;
  assign src_mode = (out_mode != readout_pkg::OUT_PROT_LEGACY);

  pair_buffer #(
    .WIDTH(WORD_W)
  ) u_buf (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_word),
    .out_valid (buf_valid),
    .out_ready (buf_ready),
    .out_data  (buf_word)
  );

  // A word leaves the buffer at frame start; none means zeros go out.
  assign load      = (st_q == ST_IDLE) && !cs_n_s;
  assign buf_ready = load;

  // Frame state.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
    end else begin
      unique case (st_q)
        ST_IDLE:  if (!cs_n_s) st_q <= ST_FRAME;
        ST_FRAME: if (cs_n_s) st_q <= ST_DONE;
        ST_DONE:  st_q <= ST_IDLE;
      endcase
    end
  end

  // Command capture and bit counting.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cmd_q     <= 32'h0000_0000;
      bit_cnt_q <= 6'd0;
    end else if (load) begin
      bit_cnt_q <= 6'd0;
    end else if (st_q == ST_FRAME && cap_edge) begin
      cmd_q <= {cmd_q[30:0], sdi_s};
      if (bit_cnt_q != 6'd32) begin
        bit_cnt_q <= bit_cnt_q + 6'd1;
      end
    end
  end

  // Shift out one bit per line on each launch edge; two lines halve
  // the edges per word but the edge timing is untouched.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      out_shift_q <= '0;
      line_a_q    <= 1'b0;
      line_b_q    <= 1'b0;
    end else if (load) begin
      out_shift_q <= buf_valid ? buf_word : '0;
      // Mode 00 and 10 launch the first bit at chip select.
      line_a_q <= buf_valid ? buf_word[WORD_W-1] : 1'b0;
      line_b_q <= buf_valid ? buf_word[WORD_W-2] : 1'b0;
      if (buf_valid && !cpha) begin
        out_shift_q <= dual_out ? {buf_word[WORD_W-3:0], 2'b00}
                                : {buf_word[WORD_W-2:0], 1'b0};
      end
    end else if (st_q == ST_FRAME && launch_edge &&
                 !(cpha == 1'b0 && bit_cnt_q == 6'd0)) begin
      if (dual_out) begin
        line_a_q    <= out_shift_q[WORD_W-1];
        line_b_q    <= out_shift_q[WORD_W-2];
        out_shift_q <= {out_shift_q[WORD_W-3:0], 2'b00};
      end else begin
        line_a_q    <= out_shift_q[WORD_W-1];
        out_shift_q <= {out_shift_q[WORD_W-2:0], 1'b0};
      end
    end
  end

  // Register writes land at frame end after a full command word.
  // Byte addresses index bytes inside one 32-bit word.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      for (int i = 0; i < readout_pkg::NUM_REGS; i++) begin
        regs_q[i] <= readout_pkg::REG_RESET;
      end
    end else if (st_q == ST_DONE && bit_cnt_q == 6'd32 &&
                 cmd_q[31:24] == readout_pkg::CMD_WRITE_BYTE) begin
      for (int i = 0; i < readout_pkg::NUM_REGS; i++) begin
        if (reg_slot(cmd_q[23:16]) == 5'(16 + i)) begin
          regs_q[i][8*cmd_q[17:16] +: 8] <=
            cmd_q[7:0] & 8'(wmask(4'(i)) >> (8*cmd_q[17:16]));
        end
      end
    end
  end

  // ****************************************************************
  // Source-synchronous clock and shared pin.
  // ****************************************************************
  logic [4:0] div_q;
  logic       int_clk_q;
  logic       strobe_q;

  // Internal clock divider, free running while a frame is open.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      div_q     <= 5'h00;
      int_clk_q <= 1'b0;
    end else if (st_q != ST_FRAME) begin
      div_q     <= 5'h00;
      int_clk_q <= 1'b0;
    end else if (div_q == readout_pkg::INT_CLK_DIV) begin
      div_q     <= 5'h00;
      int_clk_q <= ~int_clk_q;
    end else begin
      div_q <= div_q + 5'h01;
    end
  end

  // Strobe pin: output clock in source-synchronous modes, else low.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      strobe_q <= 1'b0;
    end else if (st_q == ST_FRAME && src_mode) begin
      strobe_q <= sync_clk_sel ? int_clk_q : sclk_s;
    end else begin
      strobe_q <= 1'b0;
    end
  end

  assign ready_strobe_pin  = strobe_q;
  assign serial_out_line_a = line_a_q;
  // The shared pin only carries data when two-bit mode is chosen.
  assign shared_flag_output_pin =
    dual_out ? line_b_q : flag_level;

  a_strobe_low_legacy: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (!src_mode && $past(!src_mode, 1)) |-> !ready_strobe_pin)
    else $error("strobe pin not low in legacy mode");

  a_shared_pin_flag: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !dual_out |-> shared_flag_output_pin == flag_level)
    else $error("shared pin lost flag function");

  a_shared_pin_data: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    dual_out |-> shared_flag_output_pin == line_b_q)
    else $error("shared pin not second data line");

  a_id_reserved_zero: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (regs_q[0] & ~readout_pkg::WMASK_IDENTITY) == 32'h0000_0000)
    else $error("identity reserved bits nonzero");

  a_reset_mode_zero: assert property (@(posedge core_clk)
    $past(!rst_n, 1) |-> (wr_mode == 2'b00 && !dual_out))
    else $error("reset did not select mode zero");

  a_strobe_follows: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (st_q == ST_FRAME && src_mode && !sync_clk_sel) |=>
      ##0 (ready_strobe_pin == $past(sclk_s, 1) || st_q != ST_FRAME))
    else $error("strobe does not follow host clock");

  a_shift_two_bits: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (st_q == ST_FRAME && launch_edge && dual_out && bit_cnt_q != 6'd0)
      |=> line_b_q == $past(out_shift_q[WORD_W-2], 1))
    else $error("second line missed its bit");

  a_one_line_default: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    $past(!rst_n, 1) |-> shared_flag_output_pin == flag_level)
    else $error("default is not single line");

  // ****************************************************************
  // Frame and register guards.
  // ****************************************************************
  // Registers may only move in the cycle after a frame has closed, so
  // a partial frame can never disturb the configuration.
  a_write_at_end: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !$stable(regs_q[3]) |-> $past(st_q == ST_DONE, 1))
    else $error("output control changed outside frame end");

  a_id_write_end: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    !$stable(device_address) |-> $past(st_q == ST_DONE, 1))
    else $error("device address changed outside frame end");

  a_count_bounded: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    bit_cnt_q <= 6'd32)
    else $error("capture count above one word");

  a_strobe_idle_low: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (st_q != ST_FRAME) |=> !ready_strobe_pin)
    else $error("strobe pin active outside a frame");

  a_line_a_reset: assert property (@(posedge core_clk)
    $past(!rst_n, 1) |-> !serial_out_line_a)
    else $error("data line not low after reset");

  a_int_clk_parked: assert property (@(posedge core_clk)
    disable iff (!rst_n)
    (st_q != ST_FRAME) |=> !int_clk_q)
    else $error("internal clock runs outside a frame");

endmodule

// ---- readout_pkg.sv ----
package readout_pkg;

  // ****************************************************************
  // Register map: byte addresses of the nine configuration words.
  // ****************************************************************
  localparam logic [7:0] ADDR_IDENTITY  = 8'h00;
  localparam logic [7:0] ADDR_RESET_PWR = 8'h04;
  localparam logic [7:0] ADDR_WRITE_PROT = 8'h08;
  localparam logic [7:0] ADDR_READ_OUT  = 8'h0c;
  localparam logic [7:0] ADDR_WORD_CTL  = 8'h10;
  localparam logic [7:0] ADDR_SPAN_SEL  = 8'h14;
  localparam logic [7:0] ADDR_THRESH_FLAG = 8'h20;
  localparam logic [7:0] ADDR_UPPER_LIM = 8'h24;
  localparam logic [7:0] ADDR_LOWER_LIM = 8'h28;
  localparam int         NUM_REGS       = 9;

  // ****************************************************************
  // Field positions and values.
  // ****************************************************************
  localparam int         DEV_ADDR_LSB     = 16;
  localparam int         DEV_ADDR_W       = 4;
  localparam logic [3:0] DEV_ADDR_RESET   = 4'h0;
  localparam int         WR_PROT_LSB      = 0;
  localparam int         OUT_PROT_LSB     = 0;
  localparam int         SYNC_CLK_SEL_BIT = 6;
  localparam int         SECOND_CFG_LSB   = 8;
  localparam logic [1:0] SECOND_CFG_DUAL  = 2'h3;
  localparam logic [1:0] OUT_PROT_LEGACY  = 2'h0;
  localparam logic [31:0] REG_RESET       = 32'h0000_0000;
  // Writable bits of each word; identity, read-out and write-protocol words have their own mask, the rest use WMASK_OTHER.
  localparam logic [31:0] WMASK_IDENTITY  = 32'h000f_0000;
  localparam logic [31:0] WMASK_READ_OUT  = 32'h0000_0343;
  localparam logic [31:0] WMASK_WRITE_PROT = 32'h0000_0003;
  localparam logic [31:0] WMASK_OTHER     = 32'hffff_ffff;

  // ****************************************************************
  // Frame and register-access constants.
  // ****************************************************************
  localparam int         WORD_BITS        = 32;
  localparam logic [7:0] CMD_READ         = 8'h48;
  localparam logic [7:0] CMD_WRITE_BYTE   = 8'hd0;
  localparam logic [4:0] INT_CLK_DIV      = 5'h01;

endpackage

// ---- pair_buffer.sv ----
`timescale 1ns/1ps
// Two-entry buffer with valid and ready on both sides.
module pair_buffer #(
  parameter int WIDTH = 32
) (
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);

  logic [WIDTH-1:0] slot_q [2];
  logic             rd_ptr_q;
  logic             wr_ptr_q;
  logic [1:0]       count_q;
  logic             push;
  logic             pop;

  // Full and empty come straight from the occupancy count.
  assign in_ready  = (count_q != 2'd2);
  assign out_valid = (count_q != 2'd0);
  assign out_data  = slot_q[rd_ptr_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  // Storage; written only on an accepted push.
  always_ff @(posedge core_clk) begin
    if (push) begin
      slot_q[wr_ptr_q] <= in_data;
    end
  end

  // Pointers and count.
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rd_ptr_q <= 1'b0;
      wr_ptr_q <= 1'b0;
      count_q  <= 2'd0;
    end else begin
      if (push) begin
        wr_ptr_q <= ~wr_ptr_q;
      end
      if (pop) begin
        rd_ptr_q <= ~rd_ptr_q;
      end
      count_q <= count_q + {1'b0, push} - {1'b0, pop};
    end
  end

  a_never_overflow: assert property (@(posedge core_clk) disable iff (!rst_n)
    count_q <= 2'd2)
    else $error("pair buffer count above two");

endmodule

// ---- host_model.sv ----
`timescale 1ns/1ps
// ****************************
// Host controller on the link.
// ****************************
module host_model (
  input  wire logic core_clk,
  output logic      cs_n_pin,
  output logic      sclk_pin,
  output logic      sdi_pin,
  input  wire logic serial_out_line_a,
  input  wire logic shared_flag_output_pin,
  input  wire logic ready_strobe_pin
);
  // Half period of the link clock, kept above four core cycles.
  localparam int HALF = 6;
  int   strobe_rises = 0;
  logic strobe_prev  = 1'b0;
  // Idle lines: deselected, clock parked.
  initial begin
    cs_n_pin = 1'b1;
    sclk_pin = 1'b0;
    sdi_pin  = 1'b1;
  end
  // Counts output clock rises while a frame is open.
  always @(posedge core_clk) begin
    if (!cs_n_pin && ready_strobe_pin && !strobe_prev) begin
      strobe_rises++;
    end
    strobe_prev <= ready_strobe_pin;
  end
  // Waits half a link period and steps just past the edge.
  task automatic half();
    repeat (HALF) @(posedge core_clk);
    #1;
  endtask
  // One frame of n capture edges; both output lines are recorded.
  task automatic frame(input logic [1:0] mode, input logic [31:0] tx,
                       input int n, output logic [31:0] ra,
                       output logic [31:0] rb);
    logic cpha;
    cpha = mode[0];
    ra = 32'h0000_0000;
    rb = 32'h0000_0000;
    sclk_pin = mode[1];
    half();
    strobe_rises = 0;
    cs_n_pin = 1'b0;
    half();
    for (int i = 0; i < n; i++) begin
      if (cpha) begin
        sclk_pin = ~sclk_pin;
      end
      sdi_pin = tx[31-i];
      half();
      ra = {ra[30:0], serial_out_line_a};
      rb = {rb[30:0], shared_flag_output_pin};
      sclk_pin = ~sclk_pin;
      half();
      if (!cpha) begin
        sclk_pin = ~sclk_pin;
      end
    end
    half();
    cs_n_pin = 1'b1;
    // A released line must not look like it still holds the last bit.
    sdi_pin = ~sdi_pin;
    half();
  endtask
endmodule

// ---- tb.sv ----
`timescale 1ns/1ps
// **************************************
// Self-checking bench of the readout block.
// **************************************
module tb;
  logic        core_clk     = 1'b0;
  logic        rst_n        = 1'b0;
  logic        flag_level   = 1'b0;
  logic        sample_valid = 1'b0;
  logic [31:0] sample_word  = 32'h0000_0000;
  logic        cs_n_pin, sclk_pin, sdi_pin, sample_ready;
  logic        serial_out_line_a, shared_flag_output_pin, ready_strobe_pin;
  logic [3:0]  device_address;
  int          mismatches   = 0;
  int          n_checks     = 0;
  int          cycles       = 0;
  logic [31:0] rng          = 32'h0001_824f;
  logic [31:0] q[$];
  logic [1:0]  wmode        = 2'h0;
  logic        dual         = 1'b0;
  logic        src          = 1'b0;
  logic        intclk       = 1'b0;
  logic [3:0]  addr_m       = 4'h0;
  logic [7:0]  junk [7]     = '{8'h00, 8'h01, 8'h03, 8'h0e, 8'h1a,
                                8'h1d, 8'h2d};

  serial_readout i_dut (
    .core_clk(core_clk), .rst_n(rst_n), .cs_n_pin(cs_n_pin),
    .sclk_pin(sclk_pin), .sdi_pin(sdi_pin),
    .serial_out_line_a(serial_out_line_a),
    .shared_flag_output_pin(shared_flag_output_pin),
    .ready_strobe_pin(ready_strobe_pin), .flag_level(flag_level),
    .sample_valid(sample_valid), .sample_ready(sample_ready),
    .sample_word(sample_word), .device_address(device_address)
  );
  host_model i_host (
    .core_clk(core_clk), .cs_n_pin(cs_n_pin), .sclk_pin(sclk_pin),
    .sdi_pin(sdi_pin), .serial_out_line_a(serial_out_line_a),
    .shared_flag_output_pin(shared_flag_output_pin),
    .ready_strobe_pin(ready_strobe_pin)
  );

  // Core clock at 100 MHz.
  always #5 core_clk = ~core_clk;

  // Watchdog: a hang counts as a mismatch and closes the run.
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 40000) begin
      mismatches++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction

  // Offers one sample word and holds it until the buffer takes it.
  task automatic push(input logic [31:0] w);
    @(posedge core_clk) #1;
    sample_valid = 1'b1;
    sample_word = w;
    while (sample_ready !== 1'b1) @(posedge core_clk) #1;
    @(posedge core_clk) #1;
    sample_valid = 1'b0;
    q.push_back(w);
  endtask

  // One frame; the model pops the word the device should send.
  task automatic xfer(input logic [31:0] tx, input int n, input bit chk);
    logic [31:0] ra, rb, ea, eb, w;
    w = rnd();
    flag_level = w[9];
    w = (q.size() > 0) ? q.pop_front() : 32'h0000_0000;
    ea = 32'h0000_0000;
    eb = 32'h0000_0000;
    i_host.frame(wmode, tx, n, ra, rb);
    if (chk) begin
      for (int k = 0; k < n; k++) begin
        ea = {ea[30:0], dual ? w[31-2*k] : w[31-k]};
        eb = {eb[30:0], dual ? w[30-2*k] : flag_level};
      end
      check(ra, ea);
      check(rb, eb);
    end
    if (!src) begin
      check(32'(i_host.strobe_rises), 32'h0);
    end else if (!intclk) begin
      check(32'(i_host.strobe_rises), 32'(n));
    end else begin
      check(32'(i_host.strobe_rises > n), 32'h1);
    end
  endtask

  // Byte write frame, then the model's view of the registers.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer({readout_pkg::CMD_WRITE_BYTE, a, 8'h00, d}, 32, !dual && !intclk);
    if (a == 8'h02) addr_m = d[3:0];
    if (a == 8'h08) wmode = d[1:0];
    if (a == 8'h0c) begin
      src = (d[1:0] != 2'h0);
      intclk = d[6];
    end
    if (a == 8'h0d) dual = (d[1:0] == readout_pkg::SECOND_CFG_DUAL);
    check(32'(device_address), 32'(addr_m));
  endtask

  // Main sequence.
  initial begin
    logic [31:0] w;
    repeat (4) @(posedge core_clk);
    #1;
    rst_n = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    check(32'(device_address), 32'h0);
    check(32'(shared_flag_output_pin), 32'(flag_level));
    check(32'(ready_strobe_pin), 32'h0);
    // Fill the buffer with the host stalling, then drain past empty.
    push(rnd());
    push(rnd());
    check(32'(sample_ready), 32'h0);
    repeat (3) xfer(32'h0000_0000, 32, 1);
    // Identity field, reserved bytes, gaps, and a short frame.
    w = rnd();
    wr(8'h02, w[7:0] | 8'h01);
    foreach (junk[i]) wr(junk[i], 8'hff);
    push(rnd());
    xfer({readout_pkg::CMD_WRITE_BYTE, 8'h02, 16'h0000}, 24, 1);
    check(32'(device_address), 32'(addr_m));
    // Every write protocol against every second-line setting.
    for (int m = 0; m < 4; m++) begin
      wr(8'h08, 8'(m));
      for (int v = 0; v < 4; v++) begin
        wr(8'h0d, 8'(v));
        push(rnd());
        xfer(32'h0000_0000, dual ? 16 : 32, 1);
      end
    end
    wr(8'h0d, 8'h00);
    wr(8'h08, 8'h00);
    // Source-synchronous reads, host clock then internal clock.
    wr(8'h0c, 8'h01);
    push(rnd());
    xfer(32'h0000_0000, 32, 1);
    wr(8'h0d, 8'h03);
    wr(8'h0c, 8'h02);
    push(rnd());
    xfer(32'h0000_0000, 16, 1);
    wr(8'h0c, 8'h43);
    xfer(32'h0000_0000, 16, 0);
    wr(8'h0c, 8'h00);
    wr(8'h0d, 8'h00);
    xfer(32'h0000_0000, 32, 1);
    end_sim();
  end
endmodule
